// [logic/spm_top.sv]
// spm_top: power state controller with battery warnings and pack selection
// assumes button and battery inputs are asynchronous pins, apb on clk
`timescale 1ns/1ps
`default_nettype none

// How it works
// - low level one: flash indicator, beep once each fifteen seconds
// - critical level: hibernate when enabled and hibernation file saved, else suspend; in suspend, critical hibernates even when not enabled
// - while critical persists, suspend button does not wake from suspend; ring or alarm still do
// - one pack supplies at a time; switch to next when depleted
// - beep when battery goes low and when supply switches pack
// - led steady while charging, blinking when low, dark when full
// - hibernation timeout 0.5 to 15 minutes in half minute steps
// - drive idle or screen timeout expiry enters local standby, powers down
// - local standby throttles processor clock
// - idle calls when enabled put processor in stop grant
// - off plus power button: power on, best performance, defaults, then on
// - on plus power button: smi, firmware confirms off or stays on
// - on plus suspend: smi, firmware saves to dram, then suspend
// - on plus hibernation button or timer: smi, power off after disk save
// - on plus os idle request: stop processor clock, system idle
// - system idle plus interrupt or smi: restart clock, back to on
// - on plus critical: smi, hibernate if enabled and file exists else suspend
// - suspend plus button, ring or alarm: restart clock, power up, on
// - suspend plus timer or critical: clock on, stay or hibernate after save
// - suspend plus one percent level: power off, go to off
// - hibernation plus power button: power up, on or back if aborted
module spm_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// buttons and wake pins
	input  wire logic        pwr_btn,
	input  wire logic        susp_btn,
	input  wire logic        hib_btn,
	input  wire logic        ring_in,
	input  wire logic        alarm_in,
	input  wire logic        irq_in,
	// battery sense
	input  wire logic        batt_low1,
	input  wire logic        batt_crit,
	input  wire logic        batt_exhaust,
	input  wire logic        batt_charging,
	input  wire logic        pack_depleted,
	// subsystem timeouts
	input  wire logic        hdd_timeout,
	input  wire logic        scr_timeout,
	// outputs
	output logic             sys_pwr_on,
	output logic             dev_pwr_on,
	output logic             best_perf,
	output logic             cpu_clk_stop,
	output logic             cpu_throttle,
	output logic             stop_grant,
	output logic             hdd_pwr_down,
	output logic             scr_pwr_down,
	output logic             smi,
	output logic             led_charge,
	output logic             batt_flash,
	output logic             beep,
	output logic             pack_sel
);

	localparam int NSYNC = 13;

	typedef struct packed {
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [NSYNC-1:0] s3;
		spm_pkg::spm_state_t st;
		spm_pkg::spm_pend_t  pend;
		logic [31:0]         ctrl;
		logic [spm_pkg::EV_W-1:0] evt;
		logic                smi;
		logic                stby;
		logic [31:0]         beep_cnt;
		logic [7:0]          beep_len;
		logic [32:0]         step_cnt;
		logic [4:0]          hib_cnt;
		logic                hib_exp;
		logic [24:0]         blink;
		logic                pack;
		logic [31:0]         prdata;
	} spm_regs_t;

	spm_regs_t r_reg;
	spm_regs_t r_next;

	logic [NSYNC-1:0] pins;
	logic [NSYNC-1:0] lv;
	logic [NSYNC-1:0] rise;
	logic             wr;
	logic             rd;
	logic [31:0]      cmd;
	logic             crit;
	logic [4:0]       hib_steps;

	// synchroniser input order
	localparam int I_PWR = 0;
	localparam int I_SUS = 1;
	localparam int I_HIB = 2;
	localparam int I_RNG = 3;
	localparam int I_ALM = 4;
	localparam int I_IRQ = 5;
	localparam int I_LO1 = 6;
	localparam int I_CRT = 7;
	localparam int I_EXH = 8;
	localparam int I_CHG = 9;
	localparam int I_DEP = 10;
	localparam int I_HDD = 11;
	localparam int I_SCR = 12;

	function automatic logic [4:0] clamp_steps(input logic [4:0] v);
		if (v < spm_pkg::HIB_STEPS_MIN)
			return spm_pkg::HIB_STEPS_MIN;
		else if (v > spm_pkg::HIB_STEPS_MAX)
			return spm_pkg::HIB_STEPS_MAX;
		else
			return v;
	endfunction : clamp_steps

	assign pins = {scr_timeout, hdd_timeout, pack_depleted, batt_charging, batt_exhaust,
		batt_crit, batt_low1, irq_in, alarm_in, ring_in, hib_btn, susp_btn, pwr_btn};
	assign lv   = r_reg.s2;
	assign rise = r_reg.s2 & ~r_reg.s3;
	assign wr   = psel & penable & pwrite;
	assign rd   = psel & ~penable & ~pwrite;
	assign cmd  = (wr && paddr == spm_pkg::CMD_OFS) ? pwdata : 32'h0000_0000;
	assign crit = lv[I_CRT];
	assign hib_steps = clamp_steps(r_reg.ctrl[spm_pkg::CTRL_HIB_HI:spm_pkg::CTRL_HIB_LO]);

	always_comb
	begin
		r_next          = r_reg;
		r_next.s1       = pins;
		r_next.s2       = r_reg.s1;
		r_next.s3       = r_reg.s2;
		r_next.smi      = 1'b0;
		r_next.hib_exp  = 1'b0;

		// apb registers
		if (wr && paddr == spm_pkg::CTRL_OFS)
		begin
			r_next.ctrl = pwdata;
			r_next.ctrl[spm_pkg::CTRL_HIB_HI:spm_pkg::CTRL_HIB_LO] =
				clamp_steps(pwdata[spm_pkg::CTRL_HIB_HI:spm_pkg::CTRL_HIB_LO]);
		end
		// events cleared first, so a set below wins
		if (wr && paddr == spm_pkg::EVT_OFS)
			r_next.evt = r_reg.evt & ~pwdata[spm_pkg::EV_W-1:0];
		if (rd)
		begin
			unique case (paddr)
				spm_pkg::CTRL_OFS: r_next.prdata = r_reg.ctrl;
				spm_pkg::STAT_OFS: r_next.prdata = {20'h00000, r_reg.pack, r_reg.stby, lv[I_CRT],
					lv[I_LO1], r_reg.pend, 3'h0, r_reg.st};
				spm_pkg::EVT_OFS:  r_next.prdata = {27'h0000000, r_reg.evt};
				default:           r_next.prdata = 32'h0000_0000;
			endcase
		end

		// hibernation timer runs while on or suspended
		if (r_reg.st == spm_pkg::ST_ON || r_reg.st == spm_pkg::ST_SUSPEND)
		begin
			if (r_reg.step_cnt >= 33'(spm_pkg::HIB_STEP_CYC - 1))
			begin
				r_next.step_cnt = 33'h0_0000_0000;
				if (r_reg.hib_cnt + 5'h01 >= hib_steps)
				begin
					r_next.hib_cnt = 5'h00;
					r_next.hib_exp = r_reg.ctrl[spm_pkg::CTRL_HIB_EN];
				end
				else
					r_next.hib_cnt = r_reg.hib_cnt + 5'h01;
			end
			else
				r_next.step_cnt = r_reg.step_cnt + 33'h0_0000_0001;
		end
		else
		begin
			r_next.step_cnt = 33'h0_0000_0000;
			r_next.hib_cnt  = 5'h00;
		end

		r_next.blink = r_reg.blink + 25'h0000001;
		if (r_reg.beep_len != 8'h00)
			r_next.beep_len = r_reg.beep_len - 8'h01;
		if (lv[I_LO1])
		begin
			if (r_reg.beep_cnt >= 32'(spm_pkg::BEEP_PERIOD_CYC - 1))
			begin
				r_next.beep_cnt = 32'h0000_0000;
				r_next.beep_len = 8'(spm_pkg::BEEP_LEN_CYC);
			end
			else
				r_next.beep_cnt = r_reg.beep_cnt + 32'h0000_0001;
		end
		else
			r_next.beep_cnt = 32'h0000_0000;
		if (rise[I_LO1])
			r_next.beep_len = 8'(spm_pkg::BEEP_LEN_CYC);
		if (rise[I_DEP])
		begin
			r_next.pack     = ~r_reg.pack;
			r_next.beep_len = 8'(spm_pkg::BEEP_LEN_CYC);
		end

		if (r_reg.st == spm_pkg::ST_ON && (lv[I_HDD] || lv[I_SCR]))
			r_next.stby = 1'b1;
		else if (r_reg.st != spm_pkg::ST_ON || rise[I_IRQ])
			r_next.stby = 1'b0;

		// one trigger per cycle, battery first
		unique case (r_reg.st)
			spm_pkg::ST_OFF:
			begin
				if (rise[I_PWR] && !lv[I_EXH])
					r_next.st = spm_pkg::ST_ON;
			end
			spm_pkg::ST_ON:
			begin
				if (r_reg.pend == spm_pkg::PD_NONE)
				begin
					if (crit)
					begin
						r_next.smi  = 1'b1;
						r_next.evt[spm_pkg::EV_CRIT] = 1'b1;
						r_next.pend = r_reg.ctrl[spm_pkg::CTRL_HIB_EN] ? spm_pkg::PD_HIB : spm_pkg::PD_SUSP;
					end
					else if (rise[I_PWR])
					begin
						r_next.smi  = 1'b1;
						r_next.evt[spm_pkg::EV_PWR] = 1'b1;
						r_next.pend = spm_pkg::PD_OFF;
					end
					else if (rise[I_SUS])
					begin
						r_next.smi  = 1'b1;
						r_next.evt[spm_pkg::EV_SUSP] = 1'b1;
						r_next.pend = spm_pkg::PD_SUSP;
					end
					else if (rise[I_HIB] || r_reg.hib_exp)
					begin
						r_next.smi  = 1'b1;
						r_next.evt[spm_pkg::EV_HIB] = 1'b1;
						r_next.pend = spm_pkg::PD_HIB;
					end
					else if (cmd[spm_pkg::CMD_OS_IDLE])
						r_next.st = spm_pkg::ST_IDLE;
				end
				else if (r_reg.pend == spm_pkg::PD_OFF)
				begin
					if (cmd[spm_pkg::CMD_CONFIRM_OFF])
					begin
						r_next.st   = spm_pkg::ST_OFF;
						r_next.pend = spm_pkg::PD_NONE;
					end
					else if (cmd[spm_pkg::CMD_STAY_ON])
						r_next.pend = spm_pkg::PD_NONE;
				end
				// suspend or hibernate pending, on saved: hibernate or suspend
				else if (cmd[spm_pkg::CMD_SAVED])
				begin
					if (r_reg.pend == spm_pkg::PD_HIB && (!crit || cmd[spm_pkg::CMD_HIB_FILE]))
						r_next.st = spm_pkg::ST_HIBER;
					else
						r_next.st = spm_pkg::ST_SUSPEND;
					r_next.pend = spm_pkg::PD_NONE;
				end
			end
			spm_pkg::ST_IDLE:
			begin
				if (rise[I_IRQ] || crit || rise[I_PWR] || rise[I_SUS] || rise[I_HIB])
					r_next.st = spm_pkg::ST_ON;
			end
			spm_pkg::ST_SUSPEND:
			begin
				if (lv[I_EXH])
				begin
					r_next.st   = spm_pkg::ST_OFF;
					r_next.pend = spm_pkg::PD_NONE;
				end
				else if (r_reg.pend == spm_pkg::PD_HIB)
				begin
					if (cmd[spm_pkg::CMD_SAVED])
					begin
						r_next.st   = cmd[spm_pkg::CMD_HIB_FILE] ? spm_pkg::ST_HIBER : spm_pkg::ST_SUSPEND;
						r_next.pend = spm_pkg::PD_NONE;
					end
				end
				else if (rise[I_CRT] || r_reg.hib_exp)
				begin
					r_next.smi  = 1'b1;
					r_next.evt[spm_pkg::EV_HIB] = 1'b1;
					r_next.pend = spm_pkg::PD_HIB;
				end
				else if ((rise[I_SUS] && !crit) || rise[I_RNG] || rise[I_ALM])
				begin
					r_next.smi  = 1'b1;
					r_next.evt[spm_pkg::EV_WAKE] = 1'b1;
					r_next.st   = spm_pkg::ST_ON;
				end
			end
			spm_pkg::ST_HIBER:
			begin
				if (rise[I_PWR] && !crit)
					r_next.st = spm_pkg::ST_RESUME;
			end
			spm_pkg::ST_RESUME:
			begin
				if (cmd[spm_pkg::CMD_RESUME_ABORT])
					r_next.st = spm_pkg::ST_HIBER;
				else if (cmd[spm_pkg::CMD_RESUME_OK])
					r_next.st = spm_pkg::ST_ON;
			end
			default:
				r_next.st = spm_pkg::ST_OFF;
		endcase

	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			r_reg      <= '0;
			r_reg.ctrl <= spm_pkg::CTRL_RST;
			r_reg.st   <= spm_pkg::ST_OFF;
			r_reg.pend <= spm_pkg::PD_NONE;
		end
		else
			r_reg <= r_next;
	end

	// apb answers in the access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(paddr == spm_pkg::CTRL_OFS || paddr == spm_pkg::CMD_OFS ||
		paddr == spm_pkg::STAT_OFS || paddr == spm_pkg::EVT_OFS);
	assign prdata  = r_reg.prdata;

	assign sys_pwr_on   = r_reg.st != spm_pkg::ST_OFF && r_reg.st != spm_pkg::ST_HIBER;
	assign dev_pwr_on   = r_reg.st == spm_pkg::ST_ON || r_reg.st == spm_pkg::ST_IDLE || r_reg.st == spm_pkg::ST_RESUME;
	assign best_perf    = dev_pwr_on & ~r_reg.stby;
	// clock stop in idle and in suspend with nothing pending
	assign cpu_clk_stop = (r_reg.st == spm_pkg::ST_IDLE) ||
		(r_reg.st == spm_pkg::ST_SUSPEND && r_reg.pend == spm_pkg::PD_NONE);
	assign cpu_throttle = r_reg.stby;
	assign stop_grant   = r_reg.st == spm_pkg::ST_IDLE && r_reg.ctrl[spm_pkg::CTRL_IDLE_EN];
	assign hdd_pwr_down = r_reg.stby & lv[I_HDD];
	assign scr_pwr_down = r_reg.stby & lv[I_SCR];
	assign smi          = r_reg.smi;
	assign led_charge   = lv[I_LO1] ? r_reg.blink[24] : lv[I_CHG];
	assign batt_flash   = lv[I_LO1] & r_reg.blink[24];
	assign beep         = r_reg.beep_len != 8'h00;
	assign pack_sel     = r_reg.pack;

	sequence s_off_press;
		r_reg.st == spm_pkg::ST_OFF && rise[I_PWR] && !lv[I_EXH];
	endsequence
	sequence s_on_full;
		r_reg.st == spm_pkg::ST_ON && sys_pwr_on && best_perf;
	endsequence
	property p_off_to_on;
		@(posedge clk) disable iff (!rst_b)
		s_off_press |=> s_on_full;
	endproperty
	a_off_to_on: assert property (p_off_to_on) else $error("power on from off missing");

	sequence s_on_press;
		r_reg.st == spm_pkg::ST_ON && r_reg.pend == spm_pkg::PD_NONE && !crit && rise[I_PWR];
	endsequence
	sequence s_off_asked;
		smi && r_reg.pend == spm_pkg::PD_OFF;
	endsequence
	property p_pwr_smi;
		@(posedge clk) disable iff (!rst_b)
		s_on_press |=> s_off_asked;
	endproperty
	a_pwr_smi: assert property (p_pwr_smi) else $error("power button smi missing");

	property p_os_idle;
		@(posedge clk) disable iff (!rst_b)
		(r_reg.st == spm_pkg::ST_ON && r_reg.pend == spm_pkg::PD_NONE && !crit && !rise[I_PWR] &&
			!rise[I_SUS] && !rise[I_HIB] && !r_reg.hib_exp && cmd[spm_pkg::CMD_OS_IDLE])
		|=> (r_reg.st == spm_pkg::ST_IDLE && cpu_clk_stop);
	endproperty
	a_os_idle: assert property (p_os_idle) else $error("os idle did not stop clock");

	property p_idle_wake;
		@(posedge clk) disable iff (!rst_b)
		(r_reg.st == spm_pkg::ST_IDLE && rise[I_IRQ]) |=> (r_reg.st == spm_pkg::ST_ON && !cpu_clk_stop);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake on interrupt missing");

	property p_exhaust_off;
		@(posedge clk) disable iff (!rst_b)
		(r_reg.st == spm_pkg::ST_SUSPEND && lv[I_EXH]) |=> (r_reg.st == spm_pkg::ST_OFF && !sys_pwr_on);
	endproperty
	a_exhaust_off: assert property (p_exhaust_off) else $error("exhausted suspend kept power");

	property p_crit_hold;
		@(posedge clk) disable iff (!rst_b)
		(r_reg.st == spm_pkg::ST_SUSPEND && crit && rise[I_SUS] && !lv[I_EXH] && !rise[I_RNG] &&
			!rise[I_ALM]) |=> (r_reg.st != spm_pkg::ST_ON);
	endproperty
	a_crit_hold: assert property (p_crit_hold) else $error("critical suspend woke on button");

	property p_pack_switch;
		@(posedge clk) disable iff (!rst_b)
		rise[I_DEP] |=> (pack_sel != $past(pack_sel) && beep);
	endproperty
	a_pack_switch: assert property (p_pack_switch) else $error("pack switch or beep missing");
endmodule : spm_top

`default_nettype wire

// [logic/spm_pkg.sv]
// spm_pkg: register map, field positions, states and timing for the power state manager
// assumes a 250 MHz system clock and an apb master with 32-bit data
package spm_pkg;

	// clock and timing
	localparam int          CLK_MHZ          = 250;
	localparam int          BEEP_PERIOD_S    = 15;
	localparam int          HIB_STEP_S       = 30;
	localparam longint      BEEP_PERIOD_CYC  = longint'(BEEP_PERIOD_S) * CLK_MHZ * 1000000;
	localparam longint      HIB_STEP_CYC     = longint'(HIB_STEP_S) * CLK_MHZ * 1000000;
	localparam int          BEEP_LEN_CYC     = 16;
	localparam logic [4:0]  HIB_STEPS_MIN    = 5'h01;
	localparam logic [4:0]  HIB_STEPS_MAX    = 5'h1e;

	// register byte offsets
	localparam logic [7:0]  CTRL_OFS         = 8'h00;
	localparam logic [7:0]  CMD_OFS          = 8'h04;
	localparam logic [7:0]  STAT_OFS         = 8'h08;
	localparam logic [7:0]  EVT_OFS          = 8'h0c;

	// ctrl fields
	localparam int          CTRL_HIB_EN      = 0;
	localparam int          CTRL_IDLE_EN     = 1;
	localparam int          CTRL_HIB_LO      = 8;
	localparam int          CTRL_HIB_HI      = 12;
	localparam logic [31:0] CTRL_RST         = 32'h0000_1e03;

	// cmd fields (write one to act)
	localparam int          CMD_CONFIRM_OFF  = 0;
	localparam int          CMD_STAY_ON      = 1;
	localparam int          CMD_SAVED        = 2;
	localparam int          CMD_HIB_FILE     = 3;
	localparam int          CMD_OS_IDLE      = 4;
	localparam int          CMD_RESUME_OK    = 5;
	localparam int          CMD_RESUME_ABORT = 6;

	// event bits, shared by sticky status and smi cause
	localparam int          EV_PWR           = 0;
	localparam int          EV_SUSP          = 1;
	localparam int          EV_HIB           = 2;
	localparam int          EV_CRIT          = 3;
	localparam int          EV_WAKE          = 4;
	localparam int          EV_W             = 5;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_ON      = 3'b001,
		ST_IDLE    = 3'b011,
		ST_SUSPEND = 3'b010,
		ST_HIBER   = 3'b110,
		ST_RESUME  = 3'b111
	} spm_state_t;

	// pending firmware decision while on or suspended
	typedef enum logic [1:0] {
		PD_NONE = 2'b00,
		PD_OFF  = 2'b01,
		PD_SUSP = 2'b11,
		PD_HIB  = 2'b10
	} spm_pend_t;

endpackage : spm_pkg

// [test/spm_fw_model.sv]
// spm_fw_model: firmware side, apb master for status reads and command writes
// assumes pready comes within 16 cycles; a hang ends the run in the bench
`timescale 1ns/1ps
`default_nettype none
module spm_fw_model (
	// clock
	input  wire logic        clk,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
	end

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16)
		begin
			n++;
			@(posedge clk);
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
		if (pready !== 1'b1)
		begin
			testbench.fails++;
			testbench.test_done();
		end
		@(posedge clk);
	endtask : xfer
endmodule : spm_fw_model
`default_nettype wire

// [test/testbench.sv]
// testbench: table of state transitions, then register, battery and reset cases
// assumes spm_top and the firmware model; pins act on rising edge after sync
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module testbench;
	typedef struct packed {logic [1:0] kind; logic [7:0] val; logic [2:0] st; logic [1:0] smi_n;} spm_row_t;
	// kind 0 pin pulse, 1 command write, 2 battery set, 3 battery clear; smi_n 3 skips
	localparam spm_row_t ROWS [29] = '{
		'{2'd0, 8'h00, 3'h1, 2'd0}, '{2'd1, 8'h10, 3'h3, 2'd0}, '{2'd0, 8'h05, 3'h1, 2'd0},
		'{2'd0, 8'h00, 3'h1, 2'd1}, '{2'd1, 8'h02, 3'h1, 2'd0}, '{2'd0, 8'h01, 3'h1, 2'd1},
		'{2'd1, 8'h04, 3'h2, 2'd0}, '{2'd0, 8'h03, 3'h1, 2'd1}, '{2'd1, 8'h20, 3'h1, 2'd0},
		'{2'd0, 8'h01, 3'h1, 2'd1}, '{2'd1, 8'h04, 3'h2, 2'd0}, '{2'd0, 8'h04, 3'h1, 2'd1},
		'{2'd1, 8'h20, 3'h1, 2'd0}, '{2'd0, 8'h02, 3'h1, 2'd1}, '{2'd1, 8'h0c, 3'h6, 2'd0},
		'{2'd0, 8'h00, 3'h7, 2'd0}, '{2'd1, 8'h40, 3'h6, 2'd0}, '{2'd0, 8'h00, 3'h7, 2'd0},
		'{2'd1, 8'h20, 3'h1, 2'd0}, '{2'd0, 8'h00, 3'h1, 2'd1}, '{2'd1, 8'h01, 3'h0, 2'd0},
		'{2'd0, 8'h00, 3'h1, 2'd0}, '{2'd2, 8'h01, 3'h1, 2'd1}, '{2'd1, 8'h04, 3'h2, 2'd0},
		'{2'd0, 8'h01, 3'h2, 2'd0}, '{2'd2, 8'h02, 3'h0, 2'd0}, '{2'd3, 8'h01, 3'h0, 2'd0},
		'{2'd3, 8'h02, 3'h0, 2'd0}, '{2'd0, 8'h00, 3'h1, 2'd0}};
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [5:0]  btn;
	logic [4:0]  batt;
	logic [1:0]  tmo;
	logic        sys_pwr_on, dev_pwr_on, best_perf, cpu_clk_stop, cpu_throttle, stop_grant;
	logic        hdd_pwr_down, scr_pwr_down, smi, led_charge, batt_flash, beep, pack_sel;
	logic [5:0]  outv;
	int          fails, n_checks, smi_cnt, c0;
	logic        p0;
	assign outv = {scr_pwr_down, hdd_pwr_down, cpu_throttle, led_charge, pack_sel, beep};

	spm_top i_spm_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwr_btn(btn[0]), .susp_btn(btn[1]), .hib_btn(btn[2]), .ring_in(btn[3]), .alarm_in(btn[4]),
		.irq_in(btn[5]), .batt_low1(batt[0]), .batt_crit(batt[1]), .batt_exhaust(batt[2]),
		.batt_charging(batt[3]), .pack_depleted(batt[4]), .hdd_timeout(tmo[0]), .scr_timeout(tmo[1]),
		.sys_pwr_on(sys_pwr_on), .dev_pwr_on(dev_pwr_on), .best_perf(best_perf),
		.cpu_clk_stop(cpu_clk_stop), .cpu_throttle(cpu_throttle), .stop_grant(stop_grant),
		.hdd_pwr_down(hdd_pwr_down), .scr_pwr_down(scr_pwr_down), .smi(smi),
		.led_charge(led_charge), .batt_flash(batt_flash), .beep(beep), .pack_sel(pack_sel));
	spm_fw_model i_spm_fw_model (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
		if (smi === 1'b1)
			smi_cnt++;

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_spm_fw_model.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_spm_fw_model.xfer(1'b0, a, 32'h0000_0000, q, e);
	endtask : rd
	task automatic pulse(input logic [2:0] i);
		btn[i] <= 1'b1;
		repeat (8) @(posedge clk);
		btn[i] <= 1'b0;
	endtask : pulse
	task automatic check_state(input logic [2:0] s);
		int n;
		n = 0;
		rd(spm_pkg::STAT_OFS);
		while (q[2:0] !== s && n < 8)
		begin
			n++;
			rd(spm_pkg::STAT_OFS);
		end
		`CHK(q[2:0], s)
		if (s == 3'h1 || s == 3'h3 || s == 3'h0 || s == 3'h6)
		begin
			`CHK(sys_pwr_on, (s == 3'h1 || s == 3'h3))
			`CHK(dev_pwr_on, (s == 3'h1 || s == 3'h3))
		end
		if (s == 3'h1 || s == 3'h3)
		begin
			`CHK(cpu_clk_stop, (s == 3'h3))
			`CHK(stop_grant, (s == 3'h3))
			`CHK(best_perf, 1'b1)
		end
	endtask : check_state
	task automatic wait_bit(input int b, input logic v);
		int n;
		n = 0;
		while (outv[b] !== v && n < 40)
		begin
			n++;
			@(posedge clk);
		end
		`CHK(outv[b], v)
	endtask : wait_bit
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	initial
	begin
		rst_b = 1'b0;
		btn   = 6'h00;
		batt  = 5'h00;
		tmo   = 2'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		`CHK({sys_pwr_on, dev_pwr_on, cpu_clk_stop, smi, beep, pack_sel, stop_grant, batt_flash, led_charge, pready}, 10'h001)
		rd(spm_pkg::CTRL_OFS);
		`CHK(q, spm_pkg::CTRL_RST)
		for (int r = 0; r < 29; r++)
		begin
			c0 = smi_cnt;
			case (ROWS[r].kind)
				2'd0: pulse(ROWS[r].val[2:0]);
				2'd1: wr(spm_pkg::CMD_OFS, {24'h000000, ROWS[r].val});
				2'd2: batt[ROWS[r].val[2:0]] <= 1'b1;
				default: batt[ROWS[r].val[2:0]] <= 1'b0;
			endcase
			repeat (12) @(posedge clk);
			check_state(ROWS[r].st);
			if (ROWS[r].smi_n != 2'd3)
				`CHK(smi_cnt - c0, int'(ROWS[r].smi_n))
		end
		rd(spm_pkg::EVT_OFS);
		`CHK(q, 32'h0000_001f)
		wr(spm_pkg::EVT_OFS, 32'h0000_001f);
		rd(spm_pkg::EVT_OFS);
		`CHK(q, 32'h0000_0000)
		wr(spm_pkg::CTRL_OFS, 32'h0000_0003);
		rd(spm_pkg::CTRL_OFS);
		`CHK(q[12:8], spm_pkg::HIB_STEPS_MIN)
		wr(spm_pkg::CTRL_OFS, 32'h0000_1f03);
		rd(spm_pkg::CTRL_OFS);
		`CHK(q[12:8], spm_pkg::HIB_STEPS_MAX)
		rd(8'h10);
		`CHK({e, q}, 33'h1_0000_0000)
		p0 = pack_sel;
		batt[4] <= 1'b1;
		wait_bit(0, 1'b1);
		`CHK(pack_sel, ~p0)
		batt[4] <= 1'b0;
		wait_bit(0, 1'b0);
		batt[0] <= 1'b1;
		wait_bit(0, 1'b1);
		batt[0] <= 1'b0;
		batt[3] <= 1'b1;
		wait_bit(2, 1'b1);
		batt[3] <= 1'b0;
		wait_bit(2, 1'b0);
		tmo <= 2'h3;
		wait_bit(4, 1'b1);
		wait_bit(5, 1'b1);
		wait_bit(3, 1'b1);
		`CHK(best_perf, 1'b0)
		rd(spm_pkg::STAT_OFS);
		`CHK(q[11:10], {~p0, 1'b1})
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		`CHK({sys_pwr_on, cpu_throttle, hdd_pwr_down, pack_sel, smi}, 5'h00)
		rd(spm_pkg::CTRL_OFS);
		`CHK(q, spm_pkg::CTRL_RST)
		test_done();
	end
endmodule : testbench
`default_nettype wire
